// ### nfbpc_pkg.sv
package nfbpc_pkg;
   localparam int NFBPC_ADDR_W = 25;
   localparam int NFBPC_DATA_W = 16;
   localparam int NFBPC_WAIT_POL_BIT = 10;
   localparam logic [15:0] NFBPC_RCR_RST = 16'h0000;
   localparam int NFBPC_SYNC_W = 2;
   typedef enum logic [2:0] {
      NFBPC_ST_RESET = 3'b001,
      NFBPC_ST_ASYNC = 3'b010,
      NFBPC_ST_SYNC = 3'b100
   } nfbpc_mode_e;
endpackage

// ### nfbpc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface nfbpc_sync_if;
   logic [8:0] raw;
   logic [8:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface
`default_nettype wire

// ### nfbpc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module nfbpc_sync
   import nfbpc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   nfbpc_sync_if.dst s
);
   typedef struct packed {
      logic [8:0] m;
      logic [8:0] q;
   } nfbpc_sync_s;
   nfbpc_sync_s st_r, st_nxt;
   // Reset loads each stage with the idle level of its own pin. An all-ones
   // fill would fake sync mode for one cycle and break the async start.
   // Lock-down stays kept and the supply counts as locked out until the
   // real pin levels arrive.
   localparam logic [8:0] NFBPC_IDLE_LVL = 9'h0F6;
   always_comb begin
      st_nxt = st_r;
      st_nxt.m = s.raw;
      st_nxt.q = st_r.m;
      if (!i_rst_n) begin
         st_nxt = '0;
         st_nxt.m = NFBPC_IDLE_LVL;
         st_nxt.q = NFBPC_IDLE_LVL;
      end
   end
   always_ff @(posedge i_core_clk) begin
      st_r <= st_nxt;
   end
   assign s.sync = st_r.q;
endmodule
`default_nettype wire

// ### nfbpc_top.sv
// Function
// [RQ1] Sync read: latch address on strobe rise or next clock edge with strobe low.
// [RQ2] Async mode: latch address on strobe rise, transparent while strobe low.
// [RQ3] Unused address-valid strobe is held low by the master.
// [RQ4] Die select low activates; high is standby with data and wait floating.
// [RQ5] Master keeps die select high when not accessing the device.
// [RQ6] Data driven on reads only while output-drive low; else data, wait float.
// [RQ7] Reset low clears automation and blocks all writes.
// [RQ8] Leaving reset enters asynchronous read-array mode.
// [RQ9] Wait active level is configuration bit 10.
// [RQ10] Wait driven only while die select and output-drive both low.
// [RQ11] Sync burst reads assert wait while data invalid.
// [RQ12] Async page reads and all writes keep wait deasserted.
// [RQ13] Write strobe rising edge captures address and data.
// [RQ14] Lock-guard low keeps lock-down; unlock of locked-down block fails.
// [RQ15] Lock-guard high overrides lock-down for erase and program.
// [RQ16] Program supply at or below lockout level forbids array changes.
// [RQ17] Master ties clock fixed when sync read is unused.
// [RQ18] Sixteen data lines carry writes in and read contents out.
`timescale 1ns/10ps
`default_nettype none
module nfbpc_top
   import nfbpc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_bus_clk,
   input wire logic i_address_valid_strobe_n,
   input wire logic i_die_select_n,
   input wire logic i_output_drive_n,
   input wire logic i_write_strobe_n,
   input wire logic i_lock_guard_n,
   input wire logic i_program_supply_lockout_level,
   input wire logic i_dev_rst_n,
   input wire logic [NFBPC_ADDR_W-1:0] i_addr,
   input wire logic [NFBPC_DATA_W-1:0] i_dq,
   input wire logic i_sync_mode,
   input wire logic i_rd_data_valid,
   input wire logic [NFBPC_DATA_W-1:0] i_rd_data,
   input wire logic [15:0] i_read_configuration_reg,
   input wire logic i_read_configuration_wr,
   input wire logic i_block_locked_down,
   output logic [NFBPC_DATA_W-1:0] o_dq,
   output logic o_dq_oe_n,
   output logic o_wait,
   output logic o_wait_oe_n,
   output logic [NFBPC_ADDR_W-1:0] o_addr,
   output logic o_addr_capture,
   output logic [NFBPC_ADDR_W-1:0] o_wr_addr,
   output logic [NFBPC_DATA_W-1:0] o_wr_data,
   output logic o_wr_valid,
   output logic o_unlock_allowed,
   output logic o_alter_allowed,
   output logic o_sync_mode
);
   typedef struct packed {
      nfbpc_mode_e mode;
      logic [NFBPC_ADDR_W-1:0] a1;
      logic [NFBPC_ADDR_W-1:0] a2;
      logic [NFBPC_DATA_W-1:0] d1;
      logic [NFBPC_DATA_W-1:0] d2;
      logic clk_d;
      logic adv_d;
      logic we_d;
      logic captured;
      logic [15:0] read_configuration_reg;
      logic [NFBPC_DATA_W-1:0] dq;
      logic dq_oe_n;
      logic wait_q;
      logic wait_oe_n;
      logic [NFBPC_ADDR_W-1:0] addr;
      logic addr_cap;
      logic [NFBPC_ADDR_W-1:0] wr_addr;
      logic [NFBPC_DATA_W-1:0] wr_data;
      logic wr_valid;
      logic unlock_ok;
      logic alter_ok;
      logic sync_q;
   } nfbpc_s;

   nfbpc_s st_r, st_nxt;
   nfbpc_sync_if sif ();
   logic clk_s, adv_s, cs_s, oe_s, we_s, wp_s, vpk_s, rst_s, sm_s;

   assign sif.raw = {i_bus_clk, i_address_valid_strobe_n, i_die_select_n,
                     i_output_drive_n, i_write_strobe_n, i_lock_guard_n,
                     i_program_supply_lockout_level, i_dev_rst_n,
                     i_sync_mode};
   assign {clk_s, adv_s, cs_s, oe_s, we_s, wp_s, vpk_s, rst_s, sm_s} =
      sif.sync;

   nfbpc_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .s(sif.dst)
   );

   // The wide buses are pipelined by two stages to stay aligned with the
   // synchronised strobes, so a capture sees settled values.
   always_comb begin
      st_nxt = st_r;
      st_nxt.a1 = i_addr;
      st_nxt.a2 = st_r.a1;
      st_nxt.d1 = i_dq;
      st_nxt.d2 = st_r.d1;
      st_nxt.clk_d = clk_s;
      st_nxt.adv_d = adv_s;
      st_nxt.we_d = we_s;
      st_nxt.addr_cap = 1'b0;
      st_nxt.wr_valid = 1'b0;
      if (i_read_configuration_wr) begin
         st_nxt.read_configuration_reg = i_read_configuration_reg;
      end
      // [RQ7] reset blocks writes
      if (!rst_s) begin
         st_nxt.mode = NFBPC_ST_RESET;
         st_nxt.captured = 1'b0;
      end else begin
         unique case (st_r.mode)
            // [RQ8] async after reset
            NFBPC_ST_RESET: st_nxt.mode = NFBPC_ST_ASYNC;
            NFBPC_ST_ASYNC: if (sm_s) st_nxt.mode = NFBPC_ST_SYNC;
            NFBPC_ST_SYNC: if (!sm_s) st_nxt.mode = NFBPC_ST_ASYNC;
            default: st_nxt.mode = NFBPC_ST_RESET;
         endcase
         if (!cs_s) begin
            if (st_r.mode == NFBPC_ST_SYNC) begin
               // [RQ1] first of strobe rise or clock edge
               if (adv_s && !st_r.adv_d && !st_r.captured) begin
                  st_nxt.addr = st_r.a2;
                  st_nxt.addr_cap = 1'b1;
               end else if (!adv_s && clk_s && !st_r.clk_d &&
                            !st_r.captured) begin
                  st_nxt.addr = st_r.a2;
                  st_nxt.addr_cap = 1'b1;
                  st_nxt.captured = 1'b1;
               end
               if (adv_s) st_nxt.captured = 1'b0;
            end else if (!adv_s) begin
               // [RQ2] transparent while strobe low
               st_nxt.addr = st_r.a2;
            end else if (!st_r.adv_d) begin
               st_nxt.addr = st_r.a2;
               st_nxt.addr_cap = 1'b1;
            end
            // [RQ13] write strobe rise
            if (we_s && !st_r.we_d && st_r.mode != NFBPC_ST_RESET) begin
               st_nxt.wr_addr = st_r.a2;
               st_nxt.wr_data = st_r.d2;
               st_nxt.wr_valid = 1'b1;
            end
         end
      end
      // [RQ14] lock-down holds
      // [RQ15] guard high overrides
      st_nxt.unlock_ok = wp_s || !i_block_locked_down;
      // [RQ16] supply lockout
      st_nxt.alter_ok = !vpk_s && rst_s;
      st_nxt.sync_q = st_nxt.mode == NFBPC_ST_SYNC;
      // [RQ4] [RQ6] [RQ10] output enables
      st_nxt.dq_oe_n = cs_s || oe_s || !we_s;
      st_nxt.wait_oe_n = cs_s || oe_s;
      // [RQ18] read data out
      st_nxt.dq = i_rd_data;
      // [RQ9] [RQ11] [RQ12] wait level
      if (st_r.mode == NFBPC_ST_SYNC && we_s && !i_rd_data_valid) begin
         st_nxt.wait_q = st_r.read_configuration_reg[NFBPC_WAIT_POL_BIT];
      end else begin
         st_nxt.wait_q = !st_r.read_configuration_reg[NFBPC_WAIT_POL_BIT];
      end
      if (!i_rst_n) begin
         st_nxt = '0;
         st_nxt.mode = NFBPC_ST_RESET;
         st_nxt.read_configuration_reg = NFBPC_RCR_RST;
         st_nxt.dq_oe_n = 1'b1;
         st_nxt.wait_oe_n = 1'b1;
         st_nxt.adv_d = 1'b1;
         st_nxt.we_d = 1'b1;
         st_nxt.wait_q = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      st_r <= st_nxt;
   end

   assign o_dq = st_r.dq;
   assign o_dq_oe_n = st_r.dq_oe_n;
   assign o_wait = st_r.wait_q;
   assign o_wait_oe_n = st_r.wait_oe_n;
   assign o_addr = st_r.addr;
   assign o_addr_capture = st_r.addr_cap;
   assign o_wr_addr = st_r.wr_addr;
   assign o_wr_data = st_r.wr_data;
   assign o_wr_valid = st_r.wr_valid;
   assign o_unlock_allowed = st_r.unlock_ok;
   assign o_alter_allowed = st_r.alter_ok;
   assign o_sync_mode = st_r.sync_q;
endmodule
`default_nettype wire

// ### nfbpc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module nfbpc_host_model (
   input wire logic i_core_clk
);
   logic bclk = 1'b0, bclk_on = 1'b0, adv_n = 1'b1;
   logic cs_n = 1'b1, oe_n = 1'b1, we_n = 1'b1;
   logic [24:0] addr = 25'h0000000;
   logic [15:0] dq = 16'h0000;
   always #40 if (bclk_on) bclk = ~bclk;
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic write_word(input logic [24:0] a, input logic [15:0] d);
      {cs_n, we_n, addr, dq} <= {2'b00, a, d};
      cyc(4);
      we_n <= 1'b1;
      cyc(4);
      // Released lines show the inverse so a stale value never passes.
      {cs_n, addr, dq} <= {1'b1, ~a, ~d};
      cyc(6);
   endtask
   task automatic read_word(input logic [24:0] a, input logic s);
      {cs_n, adv_n, bclk_on, addr} <= {2'b00, s, a};
      cyc(4);
      adv_n <= 1'b1;
      cyc(4);
      {oe_n, addr} <= {1'b0, ~a};
      cyc(8);
   endtask
   task automatic release_bus;
      {oe_n, cs_n, bclk_on} <= 3'b110;
      cyc(6);
   endtask
endmodule
`default_nettype wire

// ### nfbpc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module nfbpc_chk (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_die_select_n,
   input wire logic i_output_drive_n,
   input wire logic i_write_strobe_n,
   input wire logic i_lock_guard_n,
   input wire logic i_program_supply_lockout_level,
   input wire logic i_dev_rst_n,
   input wire logic i_sync_mode,
   input wire logic [15:0] i_read_configuration_reg,
   input wire logic i_block_locked_down,
   input wire logic o_dq_oe_n,
   input wire logic o_wait,
   input wire logic o_wait_oe_n,
   input wire logic o_wr_valid,
   input wire logic o_unlock_allowed,
   input wire logic o_alter_allowed
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   property p_sb;
      i_die_select_n [*4] |-> o_dq_oe_n && o_wait_oe_n;
   endproperty
   a_sb: assert property (p_sb) else $error("drive in standby");
   property p_od;
      i_output_drive_n [*4] |-> o_dq_oe_n && o_wait_oe_n;
   endproperty
   a_od: assert property (p_od) else $error("drive with oe high");
   property p_wd;
      !o_wait_oe_n |->
         !$past(i_die_select_n, 3) && !$past(i_output_drive_n, 3);
   endproperty
   a_wd: assert property (p_wd) else $error("wait driven early");
   property p_wr;
      $rose(i_write_strobe_n) && !i_die_select_n && i_dev_rst_n
         |-> ##[2:4] o_wr_valid;
   endproperty
   a_wr: assert property (p_wr) else $error("write not taken");
   property p_blk;
      !i_dev_rst_n [*4] |-> !o_wr_valid && !o_alter_allowed;
   endproperty
   a_blk: assert property (p_blk) else $error("write in reset");
   property p_lk;
      (!i_lock_guard_n && i_block_locked_down) [*4] |-> !o_unlock_allowed;
   endproperty
   a_lk: assert property (p_lk) else $error("unlock in lock-down");
   property p_vl;
      i_program_supply_lockout_level [*4] |-> !o_alter_allowed;
   endproperty
   a_vl: assert property (p_vl) else $error("alter at low supply");
   property p_wi;
      !i_sync_mode [*6] ##0 !o_wait_oe_n
         |-> o_wait == !i_read_configuration_reg[10];
   endproperty
   a_wi: assert property (p_wi) else $error("wait asserted");
   c_wr: cover property (o_wr_valid);
   c_wt: cover property (!o_wait_oe_n && o_wait);
   c_dq: cover property (!o_dq_oe_n);
endmodule
bind nfbpc_top nfbpc_chk chk (.*);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_dev_rst_n = 1'b1;
   logic i_sync_mode = 1'b0, i_rd_data_valid = 1'b0, i_lock_guard_n = 1'b0;
   logic i_program_supply_lockout_level = 1'b0, i_block_locked_down = 1'b0;
   logic i_read_configuration_wr = 1'b0;
   logic [15:0] i_rd_data = 16'h0000, i_read_configuration_reg = 16'h0000;
   logic [15:0] o_dq, o_wr_data;
   logic [24:0] o_addr, o_wr_addr;
   logic o_dq_oe_n, o_wait, o_wait_oe_n, o_addr_capture, o_wr_valid;
   logic o_unlock_allowed, o_alter_allowed, o_sync_mode;
   int num_errors = 0, comparisons = 0, ncap = 0, nwr = 0;
   nfbpc_host_model host (.i_core_clk(i_core_clk));
   wire logic i_bus_clk = host.bclk;
   wire logic i_address_valid_strobe_n = host.adv_n;
   wire logic i_die_select_n = host.cs_n;
   wire logic i_output_drive_n = host.oe_n;
   wire logic i_write_strobe_n = host.we_n;
   wire logic [24:0] i_addr = host.addr;
   wire logic [15:0] i_dq = o_dq_oe_n ? host.dq : o_dq;
   nfbpc_top dut (.*);
   initial forever #4 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      ncap <= ncap + int'(o_addr_capture === 1'b1);
      nwr <= nwr + int'(o_wr_valid === 1'b1);
   end
   task automatic chk(input string n, input logic [24:0] e, g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_write;
      int n0;
      n0 = nwr;
      host.write_word(25'h1ABCDEF, 16'hA55A);
      chk("wr count", n0 + 1, nwr);
      chk("wr addr", 25'h1ABCDEF, o_wr_addr);
      chk("wr data", 16'hA55A, o_wr_data);
      i_dev_rst_n <= 1'b0;
      host.write_word(25'h0000123, 16'h1234);
      chk("blocked", n0 + 1, nwr);
      i_dev_rst_n <= 1'b1;
      host.cyc(6);
      chk("mode", 1'b0, o_sync_mode);
      $display("write test done");
   endtask
   task automatic t_read;
      int c0;
      i_rd_data <= 16'h5AA5;
      i_rd_data_valid <= 1'b1;
      c0 = ncap;
      host.read_word(25'h0F0F0F0, 1'b0);
      chk("addr", 25'h0F0F0F0, o_addr);
      chk("async caps", c0 + 1, ncap);
      chk("dq", 16'h5AA5, i_dq);
      chk("wait oe", 1'b0, o_wait_oe_n);
      chk("wait idle", 1'b1, o_wait);
      host.release_bus();
      chk("float", 2'b11, {o_dq_oe_n, o_wait_oe_n});
      i_read_configuration_reg <= 16'h0400;
      i_read_configuration_wr <= 1'b1;
      host.cyc(1);
      i_read_configuration_wr <= 1'b0;
      i_sync_mode <= 1'b1;
      i_rd_data_valid <= 1'b0;
      c0 = ncap;
      host.read_word(25'h1555555, 1'b1);
      chk("sync mode", 1'b1, o_sync_mode);
      chk("sync addr", 25'h1555555, o_addr);
      chk("captures", c0 + 1, ncap);
      chk("wait busy", 1'b1, o_wait);
      i_rd_data_valid <= 1'b1;
      host.cyc(4);
      chk("wait ready", 1'b0, o_wait);
      host.release_bus();
      $display("read test done");
   endtask
   task automatic t_lock;
      i_block_locked_down <= 1'b1;
      i_program_supply_lockout_level <= 1'b1;
      host.cyc(6);
      chk("unlock", 1'b0, o_unlock_allowed);
      chk("alter", 1'b0, o_alter_allowed);
      i_lock_guard_n <= 1'b1;
      i_program_supply_lockout_level <= 1'b0;
      host.cyc(6);
      chk("unlock ovr", 1'b1, o_unlock_allowed);
      chk("alter ok", 1'b1, o_alter_allowed);
      $display("lock test done");
   endtask
   initial begin
      host.cyc(6);
      i_rst_n <= 1'b1;
      host.cyc(6);
      t_write();
      t_read();
      t_lock();
      test_done();
   end
   initial begin
      #20000;
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire
